//--- ctt_defines.svh
// register indices, field positions, reset values and timing constants of the clock tick timer
`ifndef CTT_DEFINES_SVH
`define CTT_DEFINES_SVH
// register indices; byte address is four times the index
`define CTT_IDX_CONTROL 16'hff78
`define CTT_IDX_COUNT_LOW 16'hff79
`define CTT_IDX_COUNT_HIGH 16'hff7a
`define CTT_IDX_IRQ_ENABLE 16'hffe6
`define CTT_IDX_IRQ_FLAGS 16'hfff6
// control register fields
`define CTT_BIT_RUN 0
`define CTT_BIT_CLEAR 1
// count taps that raise interrupts on their falling edge
`define CTT_TAP_32HZ 2
`define CTT_TAP_8HZ 4
`define CTT_TAP_2HZ 6
`define CTT_TAP_1HZ 7
// reset values
`define CTT_COUNT_RST 8'h00
`define CTT_NIB_RST 4'h0
`define CTT_WORD_ZERO 32'h0000_0000
// carry hold window, least bound, in nanoseconds
`define CTT_HOLD_MIN_NS 480000
`define CTT_CLK_PERIOD_NS 5
// least time rounds up to whole cycles
`define CTT_HOLD_CYCLES ((`CTT_HOLD_MIN_NS + `CTT_CLK_PERIOD_NS - 1) / `CTT_CLK_PERIOD_NS)
`define CTT_HOLD_W 17
`endif

//--- ctt_pkg.sv
// types shared by the clock tick timer
package ctt_pkg;
	// register selected by a bus address
	typedef enum logic [2:0] {
		CTT_REG_NONE,
		CTT_REG_CONTROL,
		CTT_REG_LOW,
		CTT_REG_HIGH,
		CTT_REG_ENABLE,
		CTT_REG_FLAGS
	} ctt_reg_e;
	// wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [17:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} ctt_wb_req_s;
	// complete state of the timer
	typedef struct packed {
		logic [7:0] count;
		logic run;
		logic hold_active;
		logic [16:0] hold_cnt;
		logic carry_pend;
		logic [3:0] flags;
		logic [3:0] enable;
		logic ack;
		logic [31:0] rdata;
	} ctt_state_s;
endpackage : ctt_pkg

//--- ctt_timer.sv
// clock tick timer: 8-bit tick counter, carry hold, tick interrupts, wishbone slave
`timescale 1ns/10ps
`include "ctt_defines.svh"

module ctt_timer #(
	parameter int HOLD_CYCLES = `CTT_HOLD_CYCLES // carry hold length, shorten in simulation
) (
	input wire logic clk_i, // 200 MHz system clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic tick_256hz_i, // one-cycle enable from the prescaler
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [17:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte selects
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	output logic irq_o // level interrupt request
);

	// last count of the hold window (hold length minus one) at the counter width
	localparam logic [16:0] HOLD_LAST = 17'(HOLD_CYCLES - 1);

	// maps a byte address to a register
	function automatic ctt_pkg::ctt_reg_e decode(input logic [17:0] adr);
		logic [15:0] idx;
		idx = adr[17:2];
		if (adr[1:0] != 2'h0) begin
			decode = ctt_pkg::CTT_REG_NONE;
		end else if (idx == `CTT_IDX_CONTROL) begin
			decode = ctt_pkg::CTT_REG_CONTROL;
		end else if (idx == `CTT_IDX_COUNT_LOW) begin
			decode = ctt_pkg::CTT_REG_LOW;
		end else if (idx == `CTT_IDX_COUNT_HIGH) begin
			decode = ctt_pkg::CTT_REG_HIGH;
		end else if (idx == `CTT_IDX_IRQ_ENABLE) begin
			decode = ctt_pkg::CTT_REG_ENABLE;
		end else if (idx == `CTT_IDX_IRQ_FLAGS) begin
			decode = ctt_pkg::CTT_REG_FLAGS;
		end else begin
			decode = ctt_pkg::CTT_REG_NONE;
		end
	endfunction : decode

	// decoded bus request, the timer state and its taps
	ctt_pkg::ctt_wb_req_s req; // bundled bus request
	ctt_pkg::ctt_state_s s; // registered state
	ctt_pkg::ctt_state_s next_s; // next state
	ctt_pkg::ctt_reg_e sel_reg; // register addressed now
	logic access; // request taken this cycle
	logic wr_lane0; // write reaching the low byte lane
	logic wr_ctrl; // write to control
	logic rd_low; // read of low nibble
	logic rd_high; // read of high nibble
	logic [3:0] tap; // interrupt taps of the count
	logic [3:0] next_tap; // taps of the next count
	logic [3:0] fall; // falling edges of the taps

	// bundle the bus inputs
	always_comb begin
		req.cyc = wb_cyc_i;
		req.stb = wb_stb_i;
		req.we = wb_we_i;
		req.adr = wb_adr_i;
		req.sel = wb_sel_i;
		req.dat = wb_dat_i;
	end

	// a request is taken at the edge where cyc and stb are high and ack is low;
	// the answer is a registered ack one cycle later, so a master that keeps
	// stb up while ack stands is not taken twice
	// only byte lane 0 carries register bits, so writes with sel[0] low are
	// answered but change nothing
	// unmapped and misaligned addresses still get an ack and read as zero
	// bus access qualifiers
	assign sel_reg = decode(req.adr);
	assign access = req.cyc & req.stb & ~s.ack;
	assign wr_lane0 = access & req.we & req.sel[0];
	assign wr_ctrl = wr_lane0 && (sel_reg == ctt_pkg::CTT_REG_CONTROL);
	assign rd_low = access & ~req.we && (sel_reg == ctt_pkg::CTT_REG_LOW);
	assign rd_high = access & ~req.we && (sel_reg == ctt_pkg::CTT_REG_HIGH);

	// carry hold: a low nibble read starts a window of HOLD_CYCLES edges
	// a wrap of the low nibble inside the window is parked in carry_pend
	// and added to the high nibble when the window ends, either at the
	// edge that takes a high read or when the window counter runs out
	// re-reading the low nibble restarts the window
	// a clear drops a parked carry, so no stale carry lands on a zero count
	// the taps are compared between the current and next count, so an edge
	// made by a clear or by a released carry also sets its flag
	// next-state logic of the whole block
	always_comb begin
		logic release_hold;
		logic [3:0] low;
		logic [3:0] high;
		logic [1:0] carries;
		release_hold = 1'b0;
		low = s.count[3:0];
		high = s.count[7:4];
		carries = 2'h0;
		next_s = s;
		next_s.ack = 1'b0;
		// hold ends on high read or when the window runs out
		if (s.hold_active && (rd_high || s.hold_cnt == HOLD_LAST)) begin
			release_hold = 1'b1;
			next_s.hold_active = 1'b0;
			next_s.carry_pend = 1'b0;
			carries = {1'b0, s.carry_pend};
		end else if (s.hold_active) begin
			next_s.hold_cnt = s.hold_cnt + 17'h1;
		end
		// count one per 256 Hz pulse while running
		if (s.run && tick_256hz_i) begin
			low = s.count[3:0] + 4'h1;
			if (s.count[3:0] == 4'hf) begin
				// low nibble wraps, carry goes high or waits
				if (s.hold_active && !release_hold) begin
					next_s.carry_pend = 1'b1;
				end else begin
					carries = carries + 2'h1;
				end
			end
		end
		high = high + {2'h0, carries};
		next_s.count = {high, low};
		// clear wins over counting and drops any held carry
		if (wr_ctrl && req.dat[`CTT_BIT_CLEAR]) begin
			next_s.count = `CTT_COUNT_RST;
			next_s.carry_pend = 1'b0;
		end
		// run control
		if (wr_ctrl) begin
			next_s.run = req.dat[`CTT_BIT_RUN];
		end
		// reading the low nibble starts the carry hold
		if (rd_low) begin
			next_s.hold_active = 1'b1;
			next_s.hold_cnt = 17'h0;
		end
		// no branch writes the count from the bus; such writes earn only an ack
		// enable register
		if (wr_lane0 && sel_reg == ctt_pkg::CTT_REG_ENABLE) begin
			next_s.enable = req.dat[3:0];
		end
		// flags: write one clears, an edge in the same cycle wins
		if (wr_lane0 && sel_reg == ctt_pkg::CTT_REG_FLAGS) begin
			next_s.flags = s.flags & ~req.dat[3:0];
		end
		next_s.flags = next_s.flags | fall;
		// answer every taken request, mapped or not
		if (access) begin
			next_s.ack = 1'b1;
			next_s.rdata = `CTT_WORD_ZERO;
			if (!req.we) begin
				case (sel_reg)
					ctt_pkg::CTT_REG_CONTROL: next_s.rdata[`CTT_BIT_RUN] = s.run;
					ctt_pkg::CTT_REG_LOW: next_s.rdata[3:0] = s.count[3:0];
					ctt_pkg::CTT_REG_HIGH: next_s.rdata[3:0] = s.count[7:4];
					ctt_pkg::CTT_REG_ENABLE: next_s.rdata[3:0] = s.enable;
					ctt_pkg::CTT_REG_FLAGS: next_s.rdata[3:0] = s.flags;
					default: next_s.rdata = `CTT_WORD_ZERO;
				endcase
			end
		end
		// reset values; synchronous, so it overrides every branch above
		// and leaves no request half taken
		if (rst_i) begin
			next_s = '0;
			next_s.count = `CTT_COUNT_RST;
			next_s.flags = `CTT_NIB_RST;
			next_s.enable = `CTT_NIB_RST;
			next_s.rdata = `CTT_WORD_ZERO;
		end
	end

	// falling edges of the 32, 8, 2 and 1 Hz taps
	assign tap = {s.count[`CTT_TAP_1HZ], s.count[`CTT_TAP_2HZ], s.count[`CTT_TAP_8HZ], s.count[`CTT_TAP_32HZ]};
	assign next_tap = {next_s.count[`CTT_TAP_1HZ], next_s.count[`CTT_TAP_2HZ],
		next_s.count[`CTT_TAP_8HZ], next_s.count[`CTT_TAP_32HZ]};
	assign fall = rst_i ? 4'h0 : (tap & ~next_tap);

	// the interrupt level follows flags and enables with no extra stage,
	// so clearing a flag drops the request at the same edge
	// state register
	always_ff @(posedge clk_i) begin
		s <= next_s;
	end

	// outputs
	assign wb_dat_o = s.rdata;
	assign wb_ack_o = s.ack;
	assign irq_o = |(s.flags & s.enable);

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_run_write: assert property (wr_ctrl |=> s.run == $past(req.dat[`CTT_BIT_RUN]))
		else $error("run bit did not follow control write");
	chk_stop_keeps: assert property (!s.run && !wr_ctrl && !s.carry_pend |=> $stable(s.count))
		else $error("stopped counter changed");
	chk_clear_zero: assert property (wr_ctrl && req.dat[`CTT_BIT_CLEAR] |=> s.count == `CTT_COUNT_RST)
		else $error("clear did not zero the counter");
	chk_ctrl_read: assert property (access && !req.we && sel_reg == ctt_pkg::CTT_REG_CONTROL
		|=> wb_ack_o && wb_dat_o[31:1] == 31'h0 && wb_dat_o[0] == $past(s.run))
		else $error("control read returned wrong bits");
	chk_count_ro: assert property (wr_lane0 && (sel_reg == ctt_pkg::CTT_REG_LOW || sel_reg == ctt_pkg::CTT_REG_HIGH)
		&& !s.run |=> $stable(s.count))
		else $error("count register write changed the count");
	chk_low_step: assert property (s.run && tick_256hz_i && !wr_ctrl
		|=> s.count[3:0] == $past(s.count[3:0]) + 4'h1)
		else $error("low nibble did not step on tick");
	chk_high_frozen: assert property (s.hold_active && !rd_high && s.hold_cnt != HOLD_LAST && !wr_ctrl
		|=> $stable(s.count[7:4]))
		else $error("high nibble moved during hold");
	chk_hold_bound: assert property (s.hold_active |-> s.hold_cnt <= HOLD_LAST)
		else $error("carry hold outlived its window");
	chk_edge_flag: assert property (fall[0] |=> s.flags[0])
		else $error("32 hz falling edge did not set its flag");
	chk_flag_clear: assert property (wr_lane0 && sel_reg == ctt_pkg::CTT_REG_FLAGS && req.dat[3] && !fall[3]
		|=> !s.flags[3])
		else $error("write one did not clear the 1 hz flag");
	chk_irq_pending: assert property (s.flags[1] && s.enable[1] |-> irq_o)
		else $error("pending request not shown on interrupt");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_reset_state: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> s.count == `CTT_COUNT_RST
		&& !s.run && s.flags == `CTT_NIB_RST && s.enable == `CTT_NIB_RST && !irq_o)
		else $error("reset left state set");

	// the clear bit never reads back
	chk_clear_reads_zero: assert property (access && !req.we && sel_reg == ctt_pkg::CTT_REG_CONTROL
		|=> wb_dat_o[`CTT_BIT_CLEAR] == 1'b0)
		else $error("clear bit read back as one");

	// low nibble read returns the low count bits
	chk_low_read_data: assert property (access && !req.we && sel_reg == ctt_pkg::CTT_REG_LOW
		|=> wb_dat_o == {28'h0000000, $past(s.count[3:0])})
		else $error("low nibble read returned wrong data");

	// high nibble read returns the high count bits
	chk_high_read_data: assert property (access && !req.we && sel_reg == ctt_pkg::CTT_REG_HIGH
		|=> wb_dat_o == {28'h0000000, $past(s.count[7:4])})
		else $error("high nibble read returned wrong data");

	// enable write lands
	chk_enable_write: assert property (wr_lane0 && sel_reg == ctt_pkg::CTT_REG_ENABLE
		|=> s.enable == $past(req.dat[3:0]))
		else $error("enable write did not land");

	// enable read returns the enables
	chk_enable_read: assert property (access && !req.we && sel_reg == ctt_pkg::CTT_REG_ENABLE
		|=> wb_dat_o == {28'h0000000, $past(s.enable)})
		else $error("enable read returned wrong data");

	// enables change only by a write
	chk_enable_hold: assert property (!(wr_lane0 && sel_reg == ctt_pkg::CTT_REG_ENABLE)
		|=> $stable(s.enable))
		else $error("enable changed without a write");

	// flag read returns the flags
	chk_flags_read: assert property (access && !req.we && sel_reg == ctt_pkg::CTT_REG_FLAGS
		|=> wb_dat_o == {28'h0000000, $past(s.flags)})
		else $error("flag read returned wrong data");

	// 8 hz falling edge sets its flag
	chk_edge_8hz: assert property (fall[1]
		|=> s.flags[1])
		else $error("8 hz falling edge did not set its flag");

	// 2 hz falling edge sets its flag
	chk_edge_2hz: assert property (fall[2]
		|=> s.flags[2])
		else $error("2 hz falling edge did not set its flag");

	// 1 hz falling edge sets its flag
	chk_edge_1hz: assert property (fall[3]
		|=> s.flags[3])
		else $error("1 hz falling edge did not set its flag");

	// writing zero leaves a set flag alone
	chk_flag_zero_write: assert property (wr_lane0 && sel_reg == ctt_pkg::CTT_REG_FLAGS && s.flags[0]
		&& !req.dat[0] |=> s.flags[0])
		else $error("zero write cleared the 32 hz flag");

	// a flag stays set until written with one
	chk_flag_sticky: assert property (s.flags[2] && !(wr_lane0 && sel_reg == ctt_pkg::CTT_REG_FLAGS
		&& req.dat[2]) |=> s.flags[2])
		else $error("2 hz flag dropped without a clear");

	// no enable, no request
	chk_irq_masked: assert property (s.enable == `CTT_NIB_RST
		|-> !irq_o)
		else $error("interrupt raised with all sources masked");

	// low read opens the hold window
	chk_hold_start: assert property (rd_low
		|=> s.hold_active && s.hold_cnt == 17'h0)
		else $error("low read did not start the hold");

	// high read closes the hold window
	chk_hold_release: assert property (s.hold_active && rd_high && !rd_low
		|=> !s.hold_active && !s.carry_pend)
		else $error("high read did not end the hold");

	// a wrap inside the window is parked
	chk_carry_defer: assert property (s.hold_active && !rd_high && s.hold_cnt != HOLD_LAST && s.run
		&& tick_256hz_i && s.count[3:0] == 4'hf && !wr_ctrl |=> s.carry_pend)
		else $error("carry during hold was not parked");

	// a parked carry lands on release
	chk_carry_add: assert property (s.hold_active && rd_high && s.carry_pend && !wr_ctrl
		&& !(s.run && tick_256hz_i) |=> s.count[7:4] == $past(s.count[7:4]) + 4'h1)
		else $error("parked carry was lost");

	// outside a hold the wrap carries at once
	chk_high_carry: assert property (!s.hold_active && s.run && tick_256hz_i && s.count[3:0] == 4'hf
		&& !wr_ctrl |=> s.count[7:4] == $past(s.count[7:4]) + 4'h1)
		else $error("low wrap did not carry into high nibble");

	// no tick, no count step
	chk_no_tick_idle: assert property (s.run && !tick_256hz_i && !wr_ctrl && !s.hold_active
		&& !s.carry_pend |=> $stable(s.count))
		else $error("count moved without a tick");

	// a parked carry exists only inside a hold
	chk_pend_in_hold: assert property (s.carry_pend
		|-> s.hold_active)
		else $error("carry parked outside a hold");

	// run bit changes only by a control write
	chk_run_hold: assert property (!wr_ctrl
		|=> s.run == $past(s.run))
		else $error("run bit changed without a write");

	// every taken request is answered next cycle
	chk_ack_take: assert property (access
		|=> wb_ack_o)
		else $error("taken request was not acknowledged");

	// unmapped reads return zero
	chk_unmapped_zero: assert property (access && !req.we && sel_reg == ctt_pkg::CTT_REG_NONE
		|=> wb_dat_o == `CTT_WORD_ZERO)
		else $error("unmapped read returned data");

endmodule : ctt_timer

//--- ctt_timer_tb_top.sv
// self-checking testbench of the clock tick timer
`timescale 1ns/10ps
`include "ctt_defines.svh"
module ctt_timer_tb_top;
	localparam int HOLD = 20; // short carry hold window for simulation
	logic clk_i = 1'b0; // system clock
	logic rst_i = 1'b1; // synchronous reset
	logic tick = 1'b0; // 256 hz enable pulse
	logic cyc = 1'b0; // bus cycle
	logic stb = 1'b0; // bus strobe
	logic we = 1'b0; // bus direction
	logic [17:0] adr = 18'h00000; // byte address
	logic [3:0] sel = 4'h0; // byte selects
	logic [31:0] dat = 32'h00000000; // write data
	logic [31:0] dat_o; // read data
	logic ack; // acknowledge
	logic irq; // interrupt level
	logic [4:0] notes[$]; // expected answers, bit 4 marks a read
	int fails = 0; // mismatches
	int compares = 0; // comparisons made
	int cycles = 0; // run length
	integer seed = 32'h1039dbed; // random seed
	logic [3:0] n; // random tick count
	logic [3:0] m; // random clear mask
	ctt_timer #(.HOLD_CYCLES(HOLD)) uut (.clk_i(clk_i), .rst_i(rst_i), .tick_256hz_i(tick), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .irq_o(irq));
	// compares a seen value against its expectation
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// prints the counts and the verdict, then stops
	task end_sim;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	// one classic wishbone cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [15:0] idx, input logic [3:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= {idx, 2'b00};
		dat <= {28'h0000000, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) begin
			fails++;
			end_sim();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	// read with the expected nibble noted
	task rd(input logic [15:0] idx, input logic [3:0] v);
		notes.push_back({1'b1, v});
		bus(1'b0, idx, 4'h0);
	endtask : rd
	// write, whose answer carries no data
	task wr(input logic [15:0] idx, input logic [3:0] v);
		notes.push_back(5'h00);
		bus(1'b1, idx, v);
	endtask : wr
	// one-cycle tick pulses
	task ticks(input int c);
		repeat (c) begin
			@(posedge clk_i);
			tick <= 1'b1;
			@(posedge clk_i);
			tick <= 1'b0;
		end
	endtask : ticks
	// clock generator
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	// watches answers and takes the oldest note
	always @(posedge clk_i) begin
		if (ack === 1'b1) begin
			if (notes.size() == 0) begin
				chk("unexpected ack", 32'h1, 32'h0);
			end else if (notes[0][4]) begin
				chk("read data", dat_o, {28'h0000000, notes[0][3:0]});
			end
			if (notes.size() != 0) begin
				void'(notes.pop_front());
			end
		end
	end
	// cuts a hang short
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			end_sim();
		end
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`CTT_IDX_CONTROL, 4'h0);
		rd(`CTT_IDX_COUNT_LOW, 4'h0);
		rd(`CTT_IDX_COUNT_HIGH, 4'h0);
		rd(`CTT_IDX_IRQ_ENABLE, 4'h0);
		rd(`CTT_IDX_IRQ_FLAGS, 4'h0);
		rd(16'h0100, 4'h0);
		ticks(3);
		rd(`CTT_IDX_COUNT_LOW, 4'h0);
		wr(`CTT_IDX_CONTROL, 4'h1);
		rd(`CTT_IDX_CONTROL, 4'h1);
		n = 4'h1 + 4'($random(seed) & 7);
		ticks(n);
		rd(`CTT_IDX_COUNT_LOW, n);
		rd(`CTT_IDX_COUNT_HIGH, 4'h0);
		wr(`CTT_IDX_CONTROL, 4'h0);
		ticks(4);
		wr(`CTT_IDX_COUNT_LOW, 4'($random(seed)));
		wr(`CTT_IDX_COUNT_HIGH, 4'($random(seed)));
		rd(`CTT_IDX_COUNT_LOW, n);
		rd(`CTT_IDX_COUNT_HIGH, 4'h0);
		wr(`CTT_IDX_CONTROL, 4'h1);
		ticks(16 - n);
		rd(`CTT_IDX_COUNT_LOW, 4'h0);
		rd(`CTT_IDX_COUNT_HIGH, 4'h1);
		ticks(15);
		rd(`CTT_IDX_COUNT_LOW, 4'hf);
		ticks(1);
		rd(`CTT_IDX_COUNT_HIGH, 4'h1);
		rd(`CTT_IDX_COUNT_HIGH, 4'h2);
		ticks(15);
		rd(`CTT_IDX_COUNT_LOW, 4'hf);
		ticks(1);
		repeat (HOLD + 10) @(posedge clk_i);
		rd(`CTT_IDX_COUNT_HIGH, 4'h3);
		wr(`CTT_IDX_CONTROL, 4'h3);
		ticks(5);
		rd(`CTT_IDX_COUNT_LOW, 4'h5);
		rd(`CTT_IDX_COUNT_HIGH, 4'h0);
		rd(`CTT_IDX_CONTROL, 4'h1);
		wr(`CTT_IDX_CONTROL, 4'h2);
		ticks(3);
		rd(`CTT_IDX_COUNT_LOW, 4'h0);
		rd(`CTT_IDX_CONTROL, 4'h0);
		wr(`CTT_IDX_IRQ_FLAGS, 4'hf);
		rd(`CTT_IDX_IRQ_FLAGS, 4'h0);
		wr(`CTT_IDX_CONTROL, 4'h1);
		ticks(8);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rd(`CTT_IDX_IRQ_FLAGS, 4'h1);
		wr(`CTT_IDX_IRQ_ENABLE, 4'h1);
		rd(`CTT_IDX_IRQ_ENABLE, 4'h1);
		chk("irq enabled", {31'h0, irq}, 32'h1);
		wr(`CTT_IDX_IRQ_FLAGS, 4'h0);
		chk("irq after zero write", {31'h0, irq}, 32'h1);
		wr(`CTT_IDX_IRQ_FLAGS, 4'h1);
		chk("irq after clear", {31'h0, irq}, 32'h0);
		wr(`CTT_IDX_IRQ_ENABLE, 4'hf);
		ticks(248);
		chk("irq all taps", {31'h0, irq}, 32'h1);
		rd(`CTT_IDX_IRQ_FLAGS, 4'hf);
		m = 4'($random(seed));
		wr(`CTT_IDX_IRQ_FLAGS, m);
		rd(`CTT_IDX_IRQ_FLAGS, ~m);
		rd(`CTT_IDX_COUNT_LOW, 4'h0);
		rd(`CTT_IDX_COUNT_HIGH, 4'h0);
		repeat (3) @(posedge clk_i);
		end_sim();
	end
endmodule : ctt_timer_tb_top
